// ==== design/display_driver_reset_sequencer.sv ====
/*
  reset and start-up sequencer of the display driver core.
  holds the core in reset, blanks the panel, reloads stored settings and
  times the release windows the host must honour.
  assumes a one-cycle-latency settings memory read port and a sleep state
  level from the command decoder; all inputs synchronous to mclk except
  the reset pin, which the filter synchronises.
*/
//
// Overview of operation
// - ignore short low pulses, long ones reset
// - reload stored settings on every release
// - finish release in 5 or 120 ms
// - blank display during reset, bounded sequence
// - reject high spikes inside valid reset
// - decode power mode from straps
`timescale 1ns/100ps
module display_driver_reset_sequencer
  import rst_seq_pkg::*;
#(
  parameter int NVM_WORDS = NVM_WORDS_DFLT,
  parameter int REL_SLEEP_IN_CYC = REL_SLEEP_IN_DFLT,
  parameter int REL_SLEEP_OUT_CYC = REL_SLEEP_OUT_DFLT,
  parameter int BLANK_SEQ_CYC = BLANK_SEQ_DFLT
)(
  input wire logic mclk,
  input wire logic reset,
  input wire logic hw_reset_n,
  input wire logic sleep_out,
  input wire logic [2:0] boost_mode_strap,
  input wire logic regulator_input_select,
  input wire logic [7:0] nvm_rdata,
  output logic nvm_rd,
  output logic [$clog2(NVM_WORDS)-1:0] nvm_addr,
  output logic core_reset,
  output logic display_blank,
  output logic blank_seq_active,
  output logic release_busy,
  output logic full_reset_seen,
  output logic cmd_ready,
  output logic sleep_out_ready,
  output logic [7:0] id1,
  output logic [7:0] id2,
  output logic [7:0] id3,
  output logic [7:0] vcom_setting,
  output logic [1:0] power_mode
);
  localparam int AW = $clog2(NVM_WORDS);

  // ----------------------------------------------------------------
  // pin classifier
  // ----------------------------------------------------------------
  rst_class_if cls ();

  reset_pin_filter u_filt (
    .mclk(mclk),
    .reset(reset),
    .hw_reset_n(hw_reset_n),
    .cls(cls)
  );

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  seq_state_e st_q, st_d;
  logic was_sleep_out_q, was_sleep_out_d;   // sleep state when reset began
  logic [REL_W-1:0] rel_cnt_q, rel_cnt_d;   // cycles since release
  logic [REL_W-1:0] blank_cnt_q, blank_cnt_d; // blanking sequence remaining
  logic rd_q, rd_d;
  logic [AW-1:0] addr_q, addr_d;
  logic core_rst_q, core_rst_d;
  logic blank_q, blank_d;
  logic busy_q, busy_d;
  logic full_q, full_d;
  logic cmd_q, cmd_d;
  logic slp_q, slp_d;
  logic [REL_W-1:0] limit;                  // release limit for captured state
  logic [7:0] word_q [NVM_WORDS];           // working copies of stored settings
  logic [1:0] pm_q, pm_d;
  logic blank_act_q, blank_act_d;           // blanking sequence running, registered for the pin

  assign limit = was_sleep_out_q ? REL_W'(REL_SLEEP_OUT_CYC) : REL_W'(REL_SLEEP_IN_CYC);
  assign blank_act_d = (blank_cnt_d != '0);

  // next values for the sequence
  always_comb begin
    st_d = st_q;
    was_sleep_out_d = was_sleep_out_q;
    rel_cnt_d = rel_cnt_q;
    blank_cnt_d = blank_cnt_q;
    rd_d = 1'b0;
    addr_d = addr_q;
    core_rst_d = core_rst_q;
    blank_d = blank_q;
    busy_d = busy_q;
    full_d = full_q | cls.full;
    cmd_d = cmd_q;
    slp_d = slp_q;
    // the release timer saturates; it gates the ready flags and the end of ST_SETTLE
    if (rel_cnt_q != {REL_W{1'b1}}) begin
      rel_cnt_d = rel_cnt_q + 1'b1;
    end
    if (blank_cnt_q != '0) begin
      blank_cnt_d = blank_cnt_q - 1'b1;
    end
    if (rel_cnt_d == REL_W'(REL_SLEEP_IN_CYC)) begin
      cmd_d = 1'b1;
    end
    if (rel_cnt_d == REL_W'(REL_SLEEP_OUT_CYC)) begin
      slp_d = 1'b1;
    end
    if (cls.start) begin
      // blank at once, from any state
      st_d = ST_BLANK;
      was_sleep_out_d = sleep_out;
      blank_cnt_d = sleep_out ? REL_W'(BLANK_SEQ_CYC) : '0;
      // park the timer so a fresh start can never reopen the ready flags
      rel_cnt_d = '1;
      core_rst_d = 1'b1;
      blank_d = 1'b1;
      busy_d = 1'b1;
      full_d = 1'b0;
      cmd_d = 1'b0;
      slp_d = 1'b0;
    end else begin
      case (st_q)
        ST_RUN: begin
          // nothing to do until the pin goes low long enough
        end
        ST_BLANK: begin
          if (cls.rel) begin
            st_d = ST_LOAD;
            rel_cnt_d = '0;
            addr_d = '0;
            rd_d = 1'b1;
          end
        end
        ST_LOAD: begin
          // rd_q high: byte still in flight; rd_q low: byte for addr_q is on the bus
          if (!rd_q) begin
            if (addr_q == AW'(NVM_WORDS - 1)) begin
              st_d = ST_SETTLE;
            end else begin
              addr_d = addr_q + 1'b1;
              rd_d = 1'b1;
            end
          end
        end
        ST_SETTLE: begin
          if (rel_cnt_d >= limit) begin
            st_d = ST_RUN;
            core_rst_d = 1'b0;
            blank_d = 1'b0;
            busy_d = 1'b0;
          end
        end
        default: begin
          st_d = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= ST_RUN;
      was_sleep_out_q <= 1'b0;
      rel_cnt_q <= '0;
      blank_cnt_q <= '0;
      blank_act_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= '0;
      core_rst_q <= 1'b0;
      blank_q <= 1'b0;
      busy_q <= 1'b0;
      full_q <= 1'b0;
      cmd_q <= 1'b1;
      slp_q <= 1'b1;
    end else begin
      st_q <= st_d;
      was_sleep_out_q <= was_sleep_out_d;
      rel_cnt_q <= rel_cnt_d;
      blank_cnt_q <= blank_cnt_d;
      blank_act_q <= blank_act_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      core_rst_q <= core_rst_d;
      blank_q <= blank_d;
      busy_q <= busy_d;
      full_q <= full_d;
      cmd_q <= cmd_d;
      slp_q <= slp_d;
    end
  end

  // ----------------------------------------------------------------
  // working copies of stored settings
  // ----------------------------------------------------------------
  // a read (rd_q) returns its byte in the following cycle, when rd_q is low
  // again and addr_q still names the word, so that is the capture cycle
  for (genvar g = 0; g < NVM_WORDS; g++) begin : g_word
    logic [7:0] w_d;
    always_comb begin
      w_d = word_q[g];
      if (st_q == ST_LOAD && !rd_q && addr_q == AW'(g)) begin
        w_d = nvm_rdata;
      end
    end
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        word_q[g] <= SETTING_RESET;
      end else begin
        word_q[g] <= w_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // power mode straps, caught at each release
  // ----------------------------------------------------------------
  // strap and select decode
  always_comb begin
    pm_d = pm_q;
    if (cls.rel) begin
      if (boost_mode_strap == STRAP_BOOST_B) begin
        pm_d = PM_3;
      end else if (boost_mode_strap == STRAP_BOOST_A) begin
        pm_d = regulator_input_select ? PM_4 : PM_2A;
      end else begin
        pm_d = PM_NONE;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pm_q <= PM_NONE;
    end else begin
      pm_q <= pm_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign nvm_rd = rd_q;
  assign nvm_addr = addr_q;
  assign core_reset = core_rst_q;
  assign display_blank = blank_q;
  assign blank_seq_active = blank_act_q;
  assign release_busy = busy_q;
  assign full_reset_seen = full_q;
  assign cmd_ready = cmd_q;
  assign sleep_out_ready = slp_q;
  assign id1 = word_q[IDX_ID1];
  assign id2 = word_q[IDX_ID2];
  assign id3 = word_q[IDX_ID3];
  assign vcom_setting = word_q[IDX_VCOM];
  assign power_mode = pm_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence reload_s;
    cls.rel ##1 (rd_q && addr_q == '0) ##1 (st_q == ST_LOAD);
  endsequence

  blank_on_start_a: assert property (cls.start |=> blank_q && core_rst_q && busy_q && !cmd_q)
    else $error("reset start did not blank the display");
  reload_start_a: assert property (cls.rel && st_q == ST_BLANK && !cls.start |-> reload_s)
    else $error("settings reload did not start at release");
  release_bound_a: assert property (busy_q && st_q != ST_BLANK |-> rel_cnt_q < limit)
    else $error("release ran past its limit");
  blank_bound_a: assert property (blank_cnt_q <= REL_W'(BLANK_SEQ_CYC))
    else $error("blanking sequence longer than allowed");
  cmd_open_a: assert property ($rose(cmd_q) |-> rel_cnt_q == REL_W'(REL_SLEEP_IN_CYC))
    else $error("commands opened at wrong time");
  mode3_a: assert property (cls.rel && boost_mode_strap == STRAP_BOOST_B |=> pm_q == PM_3)
    else $error("mode 3 strap decoded wrongly");
  mode4_a: assert property (cls.rel && boost_mode_strap == STRAP_BOOST_A && regulator_input_select |=> pm_q == PM_4)
    else $error("mode 4 strap decoded wrongly");
endmodule

// ==== design/reset_pin_filter.sv ====
/*
  synchroniser and pulse-width classifier for the active-low reset pin.
  assumes the pin is asynchronous to mclk and held by the host as a level.
*/
`timescale 1ns/100ps
module reset_pin_filter
  import rst_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic hw_reset_n,
  rst_class_if.filt cls
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic s1_q, s2_q;                  // two-stage synchroniser
  logic in_rst_q, in_rst_d;          // a valid low pulse is in progress
  logic [FILT_W-1:0] lo_q, lo_d;     // accumulated low cycles
  logic [FILT_W-1:0] hi_q, hi_d;     // current high run inside reset
  logic start_q, start_d, full_q, full_d, rel_q, rel_d;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= hw_reset_n;
      s2_q <= s1_q;
    end
  end

  // next-state for the classifier
  always_comb begin
    in_rst_d = in_rst_q;
    lo_d = lo_q;
    hi_d = '0;
    start_d = 1'b0;
    full_d = 1'b0;
    rel_d = 1'b0;
    if (!in_rst_q) begin
      if (s2_q) begin
        lo_d = '0;
      end else begin
        lo_d = lo_q + 1'b1;
        if (lo_d == FILT_W'(REJECT_CYC)) begin
          in_rst_d = 1'b1;
          start_d = 1'b1;
        end
      end
    end else if (!s2_q) begin
      // low cycles keep adding up even across short spikes
      if (lo_q != FILT_W'(FULL_CYC)) begin
        lo_d = lo_q + 1'b1;
        full_d = (lo_d == FILT_W'(FULL_CYC));
      end
    end else begin
      hi_d = hi_q + 1'b1;
      if (hi_d == FILT_W'(REJECT_CYC)) begin
        in_rst_d = 1'b0;
        rel_d = 1'b1;
        lo_d = '0;
        hi_d = '0;
      end
    end
  end

  // registers only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      in_rst_q <= 1'b0;
      lo_q <= '0;
      hi_q <= '0;
      start_q <= 1'b0;
      full_q <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      in_rst_q <= in_rst_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      start_q <= start_d;
      full_q <= full_d;
      rel_q <= rel_d;
    end
  end

  assign cls.start = start_q;
  assign cls.full = full_q;
  assign cls.rel = rel_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  start_width_a: assert property ($rose(in_rst_q) |-> lo_q == FILT_W'(REJECT_CYC) && !$past(s2_q))
    else $error("reset accepted at wrong low width");
  full_width_a: assert property (full_q |-> lo_q == FILT_W'(FULL_CYC) && in_rst_q)
    else $error("full reset flagged at wrong width");
  spike_hold_a: assert property (in_rst_q && s2_q && hi_q < FILT_W'(REJECT_CYC - 1) |=> in_rst_q)
    else $error("short high spike ended the reset");
  sync_path_a: assert property (!s2_q && !in_rst_q |=> !in_rst_q || lo_q == FILT_W'(REJECT_CYC))
    else $error("reset entered without counting");
endmodule

// ==== shared/rst_class_if.sv ====
/*
  carrier for the classified reset pin events, filter to sequencer.
  assumes both ends run on mclk; every signal is a one-cycle pulse.
*/
`timescale 1ns/100ps
interface rst_class_if;
  logic start;  // low run reached the rejection limit
  logic full;   // low cycles, summed across spikes, reached the full reset width
  logic rel;    // pin high long enough to count as released
  modport filt (output start, output full, output rel);
  modport seq (input start, input full, input rel);
endinterface

// ==== shared/rst_seq_pkg.sv ====
/*
  constants, types and timing counts shared by the reset sequencer and its pin filter.
  assumes a single 200 MHz core clock; all times are turned into cycle counts here.
*/
package rst_seq_pkg;
  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;                     // 200 MHz core clock
  localparam int CYC_PER_MS = 1000000000 / CLK_PERIOD_PS;  // whole cycles in one millisecond

  // ----------------------------------------------------------------
  // pin pulse thresholds (least times, rounded up)
  // ----------------------------------------------------------------
  localparam int T_REJECT_NS = 5000;   // shorter low pulses are spikes
  localparam int T_FULL_NS = 10000;    // longer low pulses are a full reset
  localparam int REJECT_CYC = (T_REJECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FULL_CYC = (T_FULL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_W = 12;          // pulse counter width, holds FULL_CYC

  // ----------------------------------------------------------------
  // release and blanking times (longest times, rounded down)
  // ----------------------------------------------------------------
  localparam int T_REL_SLEEP_IN_MS = 5;
  localparam int T_REL_SLEEP_OUT_MS = 120;
  localparam int T_BLANK_MAX_MS = 120;
  localparam int REL_SLEEP_IN_DFLT = T_REL_SLEEP_IN_MS * CYC_PER_MS;
  localparam int REL_SLEEP_OUT_DFLT = T_REL_SLEEP_OUT_MS * CYC_PER_MS;
  localparam int BLANK_SEQ_DFLT = T_BLANK_MAX_MS * CYC_PER_MS;
  localparam int REL_W = 25;           // release timer width, holds 24e6

  // ----------------------------------------------------------------
  // stored settings layout
  // ----------------------------------------------------------------
  localparam int NVM_WORDS_DFLT = 4;
  localparam int IDX_ID1 = 0;
  localparam int IDX_ID2 = 1;
  localparam int IDX_ID3 = 2;
  localparam int IDX_VCOM = 3;
  localparam logic [7:0] SETTING_RESET = 8'h00;  // working value before first load

  // ----------------------------------------------------------------
  // power mode straps
  // ----------------------------------------------------------------
  localparam logic [2:0] STRAP_BOOST_A = 3'h1;   // modes 2a and 4
  localparam logic [2:0] STRAP_BOOST_B = 3'h2;   // mode 3

  typedef enum logic [1:0] {
    PM_NONE = 2'b00,
    PM_2A = 2'b01,
    PM_3 = 2'b10,
    PM_4 = 2'b11
  } pwr_mode_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,     // normal operation
    ST_BLANK = 2'b01,   // pin held low, display blanked
    ST_LOAD = 2'b10,    // reloading stored settings
    ST_SETTLE = 2'b11   // waiting out the release time
  } seq_state_e;
endpackage

// ==== sim/display_driver_reset_sequencer_tb.sv ====
/*
  self-checking bench for the reset sequencer, with host model and settings memory.
  assumes shortened release counts (200/500/100 cycles) and a 4-word memory.
*/
`timescale 1ns/100ps
module display_driver_reset_sequencer_tb;
  import rst_seq_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic mclk;
  logic reset;
  logic hw_reset_n;
  logic sleep_out;
  logic [2:0] boost_mode_strap;
  logic regulator_input_select;
  logic [7:0] nvm_rdata;
  logic nvm_rd;
  logic [1:0] nvm_addr;
  logic core_reset, display_blank, blank_seq_active, release_busy;
  logic full_reset_seen, cmd_ready, sleep_out_ready;
  logic [7:0] id1, id2, id3, vcom_setting;
  logic [1:0] power_mode;
  logic [7:0] nvm_mem [4];  // stored settings image
  int error_cnt = 0;
  int n_checks = 0;

  display_driver_reset_sequencer #(.REL_SLEEP_IN_CYC(200),
    .REL_SLEEP_OUT_CYC(500), .BLANK_SEQ_CYC(100)) u_display_driver_reset_sequencer (
    .mclk(mclk), .reset(reset), .hw_reset_n(hw_reset_n), .sleep_out(sleep_out),
    .boost_mode_strap(boost_mode_strap), .regulator_input_select(regulator_input_select),
    .nvm_rdata(nvm_rdata), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .core_reset(core_reset),
    .display_blank(display_blank), .blank_seq_active(blank_seq_active),
    .release_busy(release_busy), .full_reset_seen(full_reset_seen), .cmd_ready(cmd_ready),
    .sleep_out_ready(sleep_out_ready), .id1(id1), .id2(id2), .id3(id3),
    .vcom_setting(vcom_setting), .power_mode(power_mode));

  host_model u_host_model (
    .mclk(mclk), .hw_reset_n(hw_reset_n), .sleep_out(sleep_out));

  // ------------------------------------------------------------
  // clock and settings memory
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // data one cycle after a read; toggles otherwise so stale data never matches
  always @(posedge mclk) begin
    nvm_rdata <= (nvm_rd === 1'b1) ? nvm_mem[nvm_addr] : ~nvm_rdata;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // blank, core reset and busy move together; then the two ready flags
  task automatic chk_st(input logic b, input logic c, input logic s);
    chk({3'h0, display_blank, core_reset, release_busy, cmd_ready, sleep_out_ready},
        {3'h0, b, b, b, c, s});
  endtask

  // a fresh image per reset proves the reload really happens
  task automatic fill(input int k);
    for (int i = 0; i < 4; i++) nvm_mem[i] = 8'(k * 16 + i + 5);
  endtask

  task automatic chk_ids(input int k);
    chk(id1, 8'(k * 16 + 5));
    chk(id2, 8'(k * 16 + 6));
    chk(id3, 8'(k * 16 + 7));
    chk(vcom_setting, 8'(k * 16 + 8));
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_por();
    chk_st(1'b0, 1'b1, 1'b1);
    chk({6'h0, power_mode}, {6'h0, PM_NONE});
    chk(id1, 8'h00);
    chk({7'h0, u_host_model.frame_ok()}, 8'h01);
  endtask

  // a short low run must leave the blank, core reset, busy and ready flags alone
  task automatic t_spike();
    u_host_model.pin(1'b0, 900);
    u_host_model.pin(1'b1, 1100);
    chk_st(1'b0, 1'b1, 1'b1);
  endtask

  // full reset from sleep-in with a high spike inside the low pulse
  task automatic t_sleep_in();
    fill(1);
    boost_mode_strap = 3'h1;
    regulator_input_select = 1'b0;
    u_host_model.set_sleep(1'b0);
    u_host_model.pin(1'b0, 1200);
    chk_st(1'b1, 1'b0, 1'b0);
    chk({7'h0, blank_seq_active}, 8'h00);
    u_host_model.pin(1'b1, 500);
    chk_st(1'b1, 1'b0, 1'b0);
    u_host_model.pin(1'b0, 900);
    chk({7'h0, full_reset_seen}, 8'h01);
    u_host_model.pin(1'b1, 1150);
    chk_st(1'b1, 1'b0, 1'b0);
    u_host_model.wait_cmd();
    chk_st(1'b0, 1'b1, 1'b0);
    chk_ids(1);
    chk({6'h0, power_mode}, {6'h0, PM_2A});
    u_host_model.wait_slpout();
    chk_st(1'b0, 1'b1, 1'b1);
  endtask

  // mid-width pulse from sleep-out: bounded blanking, long release
  task automatic t_sleep_out();
    fill(2);
    boost_mode_strap = 3'h2;
    regulator_input_select = 1'b1;
    u_host_model.set_sleep(1'b1);
    u_host_model.pin(1'b0, 1050);
    chk({7'h0, blank_seq_active}, 8'h01);
    u_host_model.pin(1'b0, 450);
    chk({7'h0, blank_seq_active}, 8'h00);
    chk({7'h0, full_reset_seen}, 8'h00);
    u_host_model.pin(1'b1, 0);
    u_host_model.wait_cmd();
    chk_st(1'b1, 1'b1, 1'b0);
    chk_ids(2);
    chk({6'h0, power_mode}, {6'h0, PM_3});
    u_host_model.wait_slpout();
    chk_st(1'b0, 1'b1, 1'b1);
    u_host_model.set_sleep(1'b0);
  endtask

  // remaining power modes, 4 and none
  task automatic t_modes();
    logic [2:0] st [2] = '{3'h1, 3'h3};
    logic sl [2] = '{1'b1, 1'b0};
    logic [1:0] pm [2] = '{PM_4, PM_NONE};
    for (int k = 0; k < 2; k++) begin
      fill(k + 3);
      boost_mode_strap = st[k];
      regulator_input_select = sl[k];
      u_host_model.pin(1'b0, 1100);
      u_host_model.pin(1'b1, 0);
      u_host_model.wait_slpout();
      chk({6'h0, power_mode}, {6'h0, pm[k]});
      chk_ids(k + 3);
      chk_st(1'b0, 1'b1, 1'b1);
    end
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    boost_mode_strap = 3'h0;
    regulator_input_select = 1'b0;
    fill(0);
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    t_por();
    t_spike();
    t_sleep_in();
    t_sleep_out();
    t_modes();
    close_out();
  end

  // nearly three times the expected run length
  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    $display("ERROR t=%0t timeout got=%h exp=%h", $time, 8'h00, 8'h01);
    close_out();
  end
endmodule

// ==== sim/host_model.sv ====
/*
  host side model: drives the reset pin and the panel sleep level.
  assumes the testbench calls its tasks at the falling edge of a free-running mclk.
*/
`timescale 1ns/100ps
module host_model #(
  parameter int CMD_WAIT = 1260,    // scaled command hold-off, cycles from pin release
  parameter int SLPOUT_WAIT = 1600  // scaled sleep-out hold-off, cycles from pin release
)(
  input wire logic mclk,
  output logic hw_reset_n,
  output logic sleep_out
);
  // ------------------------------------------------------------
  // pin drive and release timer
  // ------------------------------------------------------------
  int rel_cnt = 0;  // cycles since the pin went high

  initial begin
    hw_reset_n = 1'b1;
    sleep_out = 1'b0;
  end

  // counted on the rising edge so the falling-edge drive never races it
  always @(posedge mclk) begin
    rel_cnt <= hw_reset_n ? rel_cnt + 1 : 0;
  end

  // the pin is a level: set it, then hold it for n cycles
  task automatic pin(input logic lvl, input int n);
    hw_reset_n = lvl;
    repeat (n) @(negedge mclk);
  endtask

  // panel state as seen by the sequencer when a reset starts
  task automatic set_sleep(input logic v);
    sleep_out = v;
  endtask

  task automatic wait_cmd();
    while (rel_cnt < CMD_WAIT) @(negedge mclk);
  endtask

  localparam int FRAME_HZ = 60;  // frame rate the host programs
  localparam int LANES = 4;      // data lanes in use
  function automatic logic frame_ok();
    return FRAME_HZ >= 50 && FRAME_HZ <= ((LANES == 2) ? 60 : 70);
  endfunction

  task automatic wait_slpout();
    while (rel_cnt < SLPOUT_WAIT) @(negedge mclk);
  endtask
endmodule
